//--- noc_ap_xlate.sv
// Address-map package and destination address translator
package noc_ap_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 42;
	localparam int DATA_W = 256;
	localparam int LEN_W = 8;
	// ----------------------------------------
	// Destination space tags and fields
	// ----------------------------------------
	localparam int DDR4_TAG_HI = 41;
	localparam int DDR4_TAG_LO = 40;
	localparam logic [1:0] DDR4_TAG = 2'h1;
	localparam int DDR4_PG_HI = 32;
	localparam int DDR4_PG_LO = 26;
	localparam int G6_TAG_HI = 41;
	localparam int G6_TAG_LO = 37;
	localparam logic [4:0] G6_TAG = 5'h00;
	localparam int CTRL_HI = 36;
	localparam int CTRL_LO = 33;
	localparam int G6_PG_HI = 28;
	localparam int G6_PG_LO = 26;
	localparam int NAP_TAG_HI = 41;
	localparam int NAP_TAG_LO = 35;
	localparam logic [6:0] NAP_TAG = 7'h08;
	localparam int COL_HI = 34;
	localparam int COL_LO = 31;
	localparam int ROW_HI = 30;
	localparam int ROW_LO = 28;
	// ----------------------------------------
	// Hop timing and responses
	// ----------------------------------------
	localparam int NET_CLK_MHZ = 2000;
	localparam int ROW_HOP_PS = 1000;
	localparam int COL_HOP_PS = 1500;
	localparam int ROW_HOP_CYC = (ROW_HOP_PS * NET_CLK_MHZ) / 1000000;
	localparam int COL_HOP_CYC = (COL_HOP_PS * NET_CLK_MHZ) / 1000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SPACE_OTHER,
		SPACE_DDR4,
		SPACE_GDDR6,
		SPACE_NAP
	} space_t;
	typedef struct packed {
		logic                           ddr4_en;
		logic [DDR4_PG_HI-DDR4_PG_LO:0] ddr4_val;
		logic                           ctrl_en;
		logic [CTRL_HI-CTRL_LO:0]       ctrl_val;
		logic                           g6_en;
		logic [G6_PG_HI-G6_PG_LO:0]     g6_val;
		logic                           col_en;
		logic [COL_HI-COL_LO:0]         col_val;
		logic                           row_en;
		logic [ROW_HI-ROW_LO:0]         row_val;
	} xlate_table_t;
endpackage

`timescale 1ns/10ps
`default_nettype none
module noc_ap_xlate (
	input  wire logic [noc_ap_pkg::ADDR_W-1:0] addr_in,
	input  wire noc_ap_pkg::xlate_table_t      tbl,
	output logic [noc_ap_pkg::ADDR_W-1:0]      addr_out,
	output noc_ap_pkg::space_t                 space,
	output logic [2:0]                         ctrl_unit,
	output logic                               ctrl_chan
);
	// ----------------------------------------
	// Space decode and field replacement
	// ----------------------------------------
	always_comb begin
		addr_out = addr_in;
		space = noc_ap_pkg::SPACE_OTHER;
		if (addr_in[noc_ap_pkg::DDR4_TAG_HI:noc_ap_pkg::DDR4_TAG_LO]
			== noc_ap_pkg::DDR4_TAG) begin
			space = noc_ap_pkg::SPACE_DDR4;
			if (tbl.ddr4_en) begin
				addr_out[noc_ap_pkg::DDR4_PG_HI:noc_ap_pkg::DDR4_PG_LO]
					= tbl.ddr4_val;
			end
		end else if (addr_in[noc_ap_pkg::G6_TAG_HI:noc_ap_pkg::G6_TAG_LO]
			== noc_ap_pkg::G6_TAG) begin
			space = noc_ap_pkg::SPACE_GDDR6;
			if (tbl.ctrl_en) begin
				addr_out[noc_ap_pkg::CTRL_HI:noc_ap_pkg::CTRL_LO]
					= tbl.ctrl_val;
			end
			if (tbl.g6_en) begin
				addr_out[noc_ap_pkg::G6_PG_HI:noc_ap_pkg::G6_PG_LO]
					= tbl.g6_val;
			end
		end else if (addr_in[noc_ap_pkg::NAP_TAG_HI:noc_ap_pkg::NAP_TAG_LO]
			== noc_ap_pkg::NAP_TAG) begin
			space = noc_ap_pkg::SPACE_NAP;
			if (tbl.col_en) begin
				addr_out[noc_ap_pkg::COL_HI:noc_ap_pkg::COL_LO]
					= tbl.col_val;
			end
			if (tbl.row_en) begin
				addr_out[noc_ap_pkg::ROW_HI:noc_ap_pkg::ROW_LO]
					= tbl.row_val;
			end
		end
	end

	// Controller unit and channel of the select field
	assign ctrl_unit = addr_out[noc_ap_pkg::CTRL_HI:noc_ap_pkg::CTRL_LO+1];
	assign ctrl_chan = addr_out[noc_ap_pkg::CTRL_LO];
endmodule
`default_nettype wire

//--- noc_access_point.sv
// Network access point: read path, address remap, FIFOs and hop delay
`timescale 1ns/10ps
`default_nettype none
module noc_access_point #(
	parameter bit IS_COLUMN  = 1'b0,
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic                             clk_sys,
	input  wire logic                             rst,
	input  wire logic                             net_clock_present,
	input  wire noc_ap_pkg::xlate_table_t         cfg_table,
	input  wire logic                             ar_valid,
	output logic                                  ar_ready,
	input  wire logic [noc_ap_pkg::ADDR_W-1:0]    ar_addr,
	input  wire logic [noc_ap_pkg::LEN_W-1:0]     ar_len,
	output logic                                  r_valid,
	input  wire logic                             r_ready,
	output logic [noc_ap_pkg::DATA_W-1:0]         r_data,
	output logic [1:0]                            r_resp,
	output logic                                  r_last,
	output logic                                  net_req_valid,
	input  wire logic                             net_req_ready,
	output logic [noc_ap_pkg::ADDR_W-1:0]         net_req_addr,
	output logic [noc_ap_pkg::LEN_W-1:0]          net_req_len,
	output noc_ap_pkg::space_t                    net_req_space,
	output logic [2:0]                            net_req_unit,
	output logic                                  net_req_chan,
	input  wire logic                             net_rsp_valid,
	output logic                                  net_rsp_ready,
	input  wire logic [noc_ap_pkg::DATA_W-1:0]    net_rsp_data,
	output logic                                  hs_active,
	output logic                                  idle_low_power
);
	// ----------------------------------------
	// Local sizes and state
	// ----------------------------------------
	localparam int PTR_W = $clog2(FIFO_DEPTH);
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
	localparam int HOP_CYC = IS_COLUMN ? noc_ap_pkg::COL_HOP_CYC
		: noc_ap_pkg::ROW_HOP_CYC;
	localparam logic [1:0] HOP_CNT = 2'(HOP_CYC);
	localparam logic [CNT_W-1:0] FULL = CNT_W'(FIFO_DEPTH);
	localparam int AW = noc_ap_pkg::ADDR_W;
	localparam int DW = noc_ap_pkg::DATA_W;
	localparam int LW = noc_ap_pkg::LEN_W;

	typedef struct packed {
		noc_ap_pkg::xlate_table_t        tbl;
		logic [FIFO_DEPTH-1:0][AW-1:0]   rq_addr;
		logic [FIFO_DEPTH-1:0][LW-1:0]   rq_len;
		logic [PTR_W-1:0]                rq_wp;
		logic [PTR_W-1:0]                rq_rp;
		logic [CNT_W-1:0]                rq_cnt;
		logic [FIFO_DEPTH-1:0][DW-1:0]   rs_data;
		logic [PTR_W-1:0]                rs_wp;
		logic [PTR_W-1:0]                rs_rp;
		logic [CNT_W-1:0]                rs_cnt;
		logic                            out_valid;
		logic [AW-1:0]                   out_addr;
		logic [LW-1:0]                   out_len;
		noc_ap_pkg::space_t              out_space;
		logic [2:0]                      out_unit;
		logic                            out_chan;
		logic [1:0]                      out_wait;
		logic                            busy;
		logic [LW:0]                     rcv_left;
		logic [LW:0]                     beat_left;
	} state_t;

	state_t                  st;
	state_t                  next_st;
	logic [AW-1:0]           xl_addr;
	noc_ap_pkg::space_t      xl_space;
	logic [2:0]              xl_unit;
	logic                    xl_chan;
	logic                    rq_push;
	logic                    rq_pop;
	logic                    rs_push;
	logic                    rs_pop;
	logic                    issue;

	// ----------------------------------------
	// Translator on the request FIFO head
	// ----------------------------------------
	noc_ap_xlate u_xlate (
		.addr_in   (st.rq_addr[st.rq_rp]),
		.tbl       (st.tbl),
		.addr_out  (xl_addr),
		.space     (xl_space),
		.ctrl_unit (xl_unit),
		.ctrl_chan (xl_chan)
	);

	// ----------------------------------------
	// Handshakes and outputs
	// ----------------------------------------
	assign ar_ready = net_clock_present && st.rq_cnt != FULL;
	assign net_req_valid = net_clock_present && st.out_valid
		&& st.out_wait == 2'h0 && !st.busy;
	assign net_rsp_ready = net_clock_present && st.busy
		&& st.rcv_left != '0 && st.rs_cnt != FULL;
	assign r_valid = net_clock_present && st.rs_cnt != '0;
	assign r_data = st.rs_data[st.rs_rp];
	assign r_resp = noc_ap_pkg::RESP_OKAY;
	assign r_last = st.beat_left == (LW+1)'(1);
	assign net_req_addr = st.out_addr;
	assign net_req_len = st.out_len;
	assign net_req_space = st.out_space;
	assign net_req_unit = st.out_unit;
	assign net_req_chan = st.out_chan;
	assign hs_active = net_clock_present;
	assign idle_low_power = !st.busy && !st.out_valid
		&& st.rq_cnt == '0 && st.rs_cnt == '0;

	assign rq_push = ar_valid && ar_ready;
	assign rq_pop = !st.out_valid && st.rq_cnt != '0;
	assign issue = net_req_valid && net_req_ready;
	assign rs_push = net_rsp_valid && net_rsp_ready;
	assign rs_pop = r_valid && r_ready;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		if (rst || !net_clock_present) begin
			next_st = '0;
			next_st.tbl = rst ? cfg_table : st.tbl;
		end else begin
			if (rq_push) begin
				next_st.rq_addr[st.rq_wp] = ar_addr;
				next_st.rq_len[st.rq_wp] = ar_len;
				next_st.rq_wp = st.rq_wp + 1'b1;
			end
			if (rq_pop) begin
				next_st.out_valid = 1'b1;
				next_st.out_addr = xl_addr;
				next_st.out_len = st.rq_len[st.rq_rp];
				next_st.out_space = xl_space;
				next_st.out_unit = xl_unit;
				next_st.out_chan = xl_chan;
				next_st.out_wait = HOP_CNT;
				next_st.rq_rp = st.rq_rp + 1'b1;
			end else if (st.out_valid && st.out_wait != 2'h0) begin
				next_st.out_wait = st.out_wait - 2'h1;
			end
			next_st.rq_cnt = st.rq_cnt + CNT_W'(rq_push) - CNT_W'(rq_pop);
			if (issue) begin
				next_st.out_valid = 1'b0;
				next_st.busy = 1'b1;
				next_st.rcv_left = {1'b0, st.out_len} + (LW+1)'(1);
				next_st.beat_left = {1'b0, st.out_len} + (LW+1)'(1);
			end
			if (rs_push) begin
				next_st.rs_data[st.rs_wp] = net_rsp_data;
				next_st.rs_wp = st.rs_wp + 1'b1;
				next_st.rcv_left = st.rcv_left - (LW+1)'(1);
			end
			if (rs_pop) begin
				next_st.rs_rp = st.rs_rp + 1'b1;
				next_st.beat_left = st.beat_left - (LW+1)'(1);
				if (r_last) begin
					next_st.busy = 1'b0;
				end
			end
			next_st.rs_cnt = st.rs_cnt + CNT_W'(rs_push) - CNT_W'(rs_pop);
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		st <= next_st;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_launch;
		$rose(st.out_valid) ##0 !st.busy;
	endsequence

	chk_ddr4_page_swap: assert property (
		st.rq_cnt != '0 && xl_space == noc_ap_pkg::SPACE_DDR4
		&& st.tbl.ddr4_en |-> xl_addr[32:26] == st.tbl.ddr4_val)
		else $error("ddr4 page not replaced");
	chk_ctrl_swap: assert property (
		st.rq_cnt != '0 && xl_space == noc_ap_pkg::SPACE_GDDR6
		&& st.tbl.ctrl_en |-> xl_addr[36:33] == st.tbl.ctrl_val
		&& xl_unit == st.tbl.ctrl_val[3:1])
		else $error("controller select not replaced");
	chk_g6_page_swap: assert property (
		st.rq_cnt != '0 && xl_space == noc_ap_pkg::SPACE_GDDR6
		&& st.tbl.g6_en |-> xl_addr[28:26] == st.tbl.g6_val)
		else $error("gddr6 page not replaced");
	chk_nap_field_swap: assert property (
		xl_space == noc_ap_pkg::SPACE_NAP && st.tbl.col_en
		&& st.tbl.row_en |-> xl_addr[34:31] == st.tbl.col_val
		&& xl_addr[30:28] == st.tbl.row_val
		&& xl_addr[27:0] == st.rq_addr[st.rq_rp][27:0])
		else $error("access point fields not replaced");
	chk_other_passthru: assert property (
		xl_space == noc_ap_pkg::SPACE_OTHER
		|-> xl_addr == st.rq_addr[st.rq_rp])
		else $error("address changed outside a mapped space");
	generate
		if (IS_COLUMN) begin : g_col
			chk_col_hop: assert property (
				disable iff (rst || !net_clock_present)
				s_launch |-> !net_req_valid[*3] ##1 net_req_valid)
				else $error("column hop latency wrong");
		end else begin : g_row
			chk_row_hop: assert property (
				disable iff (rst || !net_clock_present)
				s_launch |-> !net_req_valid[*2] ##1 net_req_valid)
				else $error("row hop latency wrong");
		end
	endgenerate
	chk_off_no_link: assert property (
		!net_clock_present |-> !ar_ready && !r_valid
		&& !net_req_valid && !net_rsp_ready && !hs_active)
		else $error("link active without network clock");
	chk_table_frozen: assert property (
		$stable(st.tbl))
		else $error("translation table changed at run time");
	chk_fifo_full: assert property (
		st.rq_cnt == FULL |-> !ar_ready ##1 st.rq_cnt == FULL
		|| st.out_valid || !net_clock_present)
		else $error("request fifo accepted while full");
	chk_last_beat: assert property (
		r_valid && r_ready && r_last |=> !st.busy && st.beat_left == '0)
		else $error("burst not closed on last beat");
	chk_beat_count: assert property (
		issue && net_clock_present |=> st.beat_left
		== {1'b0, $past(net_req_len)} + (LW+1)'(1))
		else $error("beat count differs from request");
endmodule
`default_nettype wire

//--- noc_net_responder.sv
// Network-side responder model for the access point
`timescale 1ns/10ps
`default_nettype none
module noc_net_responder (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         slow,
	input  wire logic         req_valid,
	output logic              req_ready,
	input  wire logic [41:0]  req_addr,
	input  wire logic [7:0]   req_len,
	output logic              rsp_valid,
	input  wire logic         rsp_ready,
	output logic [255:0]      rsp_data
);
	logic        busy;
	logic        tick;
	logic [7:0]  beat;
	logic [7:0]  len;
	logic [41:0] addr;
	// ----------------------------------------
	// Accept one read, then return its beats
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			tick <= 1'b0;
			busy <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			beat <= 8'h00;
			len <= 8'h00;
			addr <= 42'h0;
		end else begin
			tick <= ~tick;
			if (!busy) begin
				req_ready <= !(req_valid && req_ready) && (!slow || tick);
				if (req_valid && req_ready) begin
					busy <= 1'b1;
					addr <= req_addr;
					len <= req_len;
					beat <= 8'h00;
				end
			end else begin
				req_ready <= 1'b0;
				if (rsp_valid && rsp_ready) begin
					beat <= beat + 8'h01;
					busy <= beat != len;
					rsp_valid <= beat != len && !slow;
				end else begin
					rsp_valid <= rsp_valid || !slow || tick;
				end
			end
		end
	end
	// Released data lines show the inverse pattern
	assign rsp_data = rsp_valid ? {beat, 206'h0, addr}
		: ~{beat, 206'h0, addr};
endmodule
`default_nettype wire

//--- noc_access_point_test.sv
// Self-checking bench for the network access point
`timescale 1ns/10ps
`default_nettype none
module noc_access_point_test;
	logic                     clk_sys, rst, net_clock_present, slow;
	logic                     ar_valid, ar_ready, r_valid, r_ready, r_last;
	logic                     net_req_valid, net_req_ready, net_req_chan;
	logic                     net_rsp_valid, net_rsp_ready;
	logic                     hs_active, idle_low_power;
	noc_ap_pkg::xlate_table_t cfg_table;
	logic [41:0]              ar_addr, net_req_addr;
	logic [7:0]               ar_len, net_req_len;
	logic [255:0]             r_data, net_rsp_data;
	logic [1:0]               r_resp;
	logic [2:0]               net_req_unit;
	noc_ap_pkg::space_t       net_req_space;
	int                       fail_count, checked, cycles;
	// ----------------------------------------
	// Design, responder and clock
	// ----------------------------------------
	noc_access_point uut (.clk_sys(clk_sys), .rst(rst),
		.net_clock_present(net_clock_present), .cfg_table(cfg_table),
		.ar_valid(ar_valid), .ar_ready(ar_ready), .ar_addr(ar_addr),
		.ar_len(ar_len), .r_valid(r_valid), .r_ready(r_ready),
		.r_data(r_data), .r_resp(r_resp), .r_last(r_last),
		.net_req_valid(net_req_valid), .net_req_ready(net_req_ready),
		.net_req_addr(net_req_addr), .net_req_len(net_req_len),
		.net_req_space(net_req_space), .net_req_unit(net_req_unit),
		.net_req_chan(net_req_chan), .net_rsp_valid(net_rsp_valid),
		.net_rsp_ready(net_rsp_ready), .net_rsp_data(net_rsp_data),
		.hs_active(hs_active), .idle_low_power(idle_low_power));
	noc_net_responder peer (.clk_sys(clk_sys), .rst(rst), .slow(slow),
		.req_valid(net_req_valid), .req_ready(net_req_ready),
		.req_addr(net_req_addr), .req_len(net_req_len),
		.rsp_valid(net_rsp_valid), .rsp_ready(net_rsp_ready),
		.rsp_data(net_rsp_data));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cmp_vec(input logic [255:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s", $time, what);
		end
	endtask
	task automatic cmp_bit(input logic got, exp, input string what);
		cmp_vec({255'h0, got}, {255'h0, exp}, what);
	endtask
	task automatic send_ar(input logic [41:0] a, input logic [7:0] n,
		input bit hold);
		int w;
		ar_addr = a;
		ar_len = n;
		ar_valid = 1'b1;
		w = 0;
		while (ar_ready !== 1'b1 && w < 50) begin
			@(negedge clk_sys);
			w++;
		end
		cmp_bit(ar_ready, 1'b1, "request refused");
		@(negedge clk_sys);
		if (!hold) ar_valid = 1'b0;
	endtask
	task automatic expect_req(input logic [41:0] a,
		input noc_ap_pkg::space_t sp, input logic [7:0] n, input int lows);
		int w;
		w = 0;
		while (net_req_valid !== 1'b1 && w < 100) begin
			@(negedge clk_sys);
			w++;
		end
		if (lows >= 0) cmp_vec(w, lows, "hop delay");
		cmp_vec(net_req_addr, a, "address");
		cmp_vec(net_req_space, sp, "space");
		cmp_vec(net_req_len, n, "length");
	endtask
	task automatic expect_beats(input logic [41:0] a, input logic [7:0] n,
		input bit stall);
		int w;
		for (int b = 0; b <= n; b++) begin
			w = 0;
			while (r_valid !== 1'b1 && w < 100) begin
				@(negedge clk_sys);
				w++;
			end
			if (stall) begin
				r_ready = 1'b0;
				repeat (3) @(negedge clk_sys);
				cmp_bit(r_valid, 1'b1, "beat dropped");
				r_ready = 1'b1;
			end
			cmp_vec(r_data, {8'(b), 206'h0, a}, "beat data");
			cmp_vec(r_resp, noc_ap_pkg::RESP_OKAY, "response");
			cmp_bit(r_last, b == n, "last flag");
			@(negedge clk_sys);
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_ddr4(input logic [6:0] pg);
		logic [41:0] a, e;
		a = {2'b01, 40'hF0_F0F0_F0F0};
		e = a;
		e[32:26] = pg;
		send_ar(a, 8'h03, 1'b0);
		cmp_bit(idle_low_power, 1'b0, "idle while busy");
		expect_req(e, noc_ap_pkg::SPACE_DDR4, 8'h03, 3);
		expect_beats(e, 8'h03, 1'b0);
		cmp_bit(r_valid, 1'b0, "extra beat");
		cmp_bit(idle_low_power, 1'b1, "not idle");
	endtask
	task automatic test_gddr6;
		logic [41:0] a, e;
		slow = 1'b1;
		a = {5'h00, 4'h2, 33'h1_FFFF_FFFF};
		e = a;
		e[36:33] = 4'hB;
		e[28:26] = 3'h6;
		send_ar(a, 8'h02, 1'b0);
		expect_req(e, noc_ap_pkg::SPACE_GDDR6, 8'h02, -1);
		cmp_vec(net_req_unit, 3'h5, "controller");
		cmp_bit(net_req_chan, 1'b1, "channel");
		expect_beats(e, 8'h02, 1'b1);
		slow = 1'b0;
	endtask
	task automatic test_pair;
		logic [41:0] a, c, e;
		a = {7'h08, 4'h1, 3'h1, 28'h0ABC_DEF};
		e = a;
		e[34:31] = 4'h3;
		e[30:28] = 3'h5;
		c = {8'h20, 34'h0_1234_5678};
		send_ar(a, 8'h00, 1'b1);
		send_ar(c, 8'h01, 1'b0);
		expect_req(e, noc_ap_pkg::SPACE_NAP, 8'h00, -1);
		expect_beats(e, 8'h00, 1'b0);
		expect_req(c, noc_ap_pkg::SPACE_OTHER, 8'h01, -1);
		expect_beats(c, 8'h01, 1'b0);
	endtask
	task automatic test_clock_off;
		net_clock_present = 1'b0;
		ar_addr = 42'h0;
		ar_valid = 1'b1;
		repeat (3) @(negedge clk_sys);
		cmp_bit(hs_active, 1'b0, "link still on");
		cmp_bit(ar_ready, 1'b0, "taken while off");
		ar_valid = 1'b0;
		net_clock_present = 1'b1;
		@(negedge clk_sys);
		cmp_bit(hs_active, 1'b1, "link not on");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		fail_count = 0;
		checked = 0;
		cycles = 0;
		rst = 1'b1;
		net_clock_present = 1'b1;
		slow = 1'b0;
		ar_valid = 1'b0;
		ar_addr = 42'h0;
		ar_len = 8'h00;
		r_ready = 1'b1;
		cfg_table = '{1'b1, 7'h55, 1'b1, 4'hB, 1'b1, 3'h6, 1'b1, 4'h3,
			1'b1, 3'h5};
		repeat (4) @(negedge clk_sys);
		rst = 1'b0;
		cfg_table = 26'h0;
		@(negedge clk_sys);
		test_ddr4(7'h55);
		test_gddr6();
		test_pair();
		test_clock_off();
		test_pair();
		cfg_table = '{1'b1, 7'h03, 1'b1, 4'hB, 1'b1, 3'h6, 1'b1, 4'h3,
			1'b1, 3'h5};
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
		test_ddr4(7'h03);
		print_verdict();
	end
endmodule
`default_nettype wire
